// ===== rtl/ftc_pkg.sv
// package for the friction torque compensation block
package ftc_pkg;
  typedef enum logic [1:0] {
    FTC_MODE_POS,
    FTC_MODE_VEL,
    FTC_MODE_TRQ,
    FTC_MODE_FULL
  } ftc_mode_t;

  localparam int FTC_PCT_W = 8;
  localparam int FTC_TRQ_W = 16;
  localparam int FTC_SPD_W = 16;
  localparam int FTC_VGAIN_W = 14;
  localparam int FTC_HGAIN_W = 15;
  localparam int FTC_HFILT_W = 16;
  localparam logic signed [FTC_PCT_W-1:0] FTC_PCT_MIN = -8'sd100;
  localparam logic signed [FTC_PCT_W-1:0] FTC_PCT_MAX = 8'sd100;
  localparam logic [FTC_VGAIN_W-1:0] FTC_VGAIN_MAX = 14'h2710;
  localparam logic [FTC_HGAIN_W-1:0] FTC_HGAIN_MAX = 15'h7530;
  localparam logic [FTC_HFILT_W-1:0] FTC_HFILT_MAX = 16'h9088;
  localparam int FTC_RATED_DEF = 4096;
  localparam int FTC_SPD_FULL_DEF = 10000;
  localparam int FTC_VGAIN_UNIT = 1000;

  typedef struct packed {
    logic signed [FTC_PCT_W-1:0] offset_load_torque_setting;
    logic signed [FTC_PCT_W-1:0] forward_friction_torque_setting;
    logic signed [FTC_PCT_W-1:0] reverse_friction_torque_setting;
    logic [FTC_VGAIN_W-1:0] viscous_friction_gain_setting;
    logic [FTC_HGAIN_W-1:0] twist_damping_gain_setting;
    logic [FTC_HFILT_W-1:0] twist_damping_filter_setting;
  } ftc_cfg_t;

  typedef struct packed {
    logic cmd_valid;
    logic signed [FTC_SPD_W-1:0] cmd_delta;
    logic signed [FTC_SPD_W-1:0] cmd_speed;
  } ftc_cmd_t;
endpackage : ftc_pkg

// ===== rtl/ftc_core.sv
// friction torque compensation adder with twist damping settings
`timescale 1ns/1ps
// Behaviour
// - offset term added except torque mode
// - forward command adds forward friction setting
// - reverse command adds reverse friction setting
// - two-dof adds speed times viscous gain except torque mode
// - compensation equals offset plus selected friction
// - direction cleared at reset and servo off
// - torque mode forces both terms zero
// - velocity servo-off: offset on, friction zero
// - hold terms until first position command
// - friction follows command direction after command
// - twist damping only full-closed with servo on
// - twist damping gain limited to 30000
// - twist damping filter limited to 37000
module ftc_core
  import ftc_pkg::*;
#(
  parameter int RATED_TRQ = FTC_RATED_DEF,
  parameter int SPD_FULL = FTC_SPD_FULL_DEF
) (
  input wire logic mclk,
  input wire logic reset,
  input wire ftc_mode_t ctrl_mode,
  input wire logic servo_on,
  input wire logic two_dof_en,
  input wire ftc_cfg_t cfg,
  input wire ftc_cmd_t cmd,
  input wire logic signed [FTC_TRQ_W-1:0] torque_in,
  output logic signed [FTC_TRQ_W-1:0] torque_out,
  output logic signed [FTC_TRQ_W-1:0] friction_torque,
  output logic twist_damp_en,
  output logic [FTC_HGAIN_W-1:0] twist_gain,
  output logic [FTC_HFILT_W-1:0] twist_filter,
  output logic [1:0] cmd_dir
);
  localparam int ACC_W = 48;
  localparam logic signed [ACC_W-1:0] TRQ_MAX = ACC_W'(2 ** (FTC_TRQ_W - 1) - 1);
  localparam logic signed [ACC_W-1:0] TRQ_MIN = -ACC_W'(2 ** (FTC_TRQ_W - 1));

  // dir: bit1 forward seen, bit0 reverse seen; zero means no direction yet
  logic [1:0] dir_q;
  logic [1:0] dir_d;
  logic seen_q;
  logic seen_d;
  logic signed [FTC_PCT_W-1:0] off_q;
  logic signed [FTC_PCT_W-1:0] off_d;
  logic signed [FTC_PCT_W-1:0] dyn_q;
  logic signed [FTC_PCT_W-1:0] dyn_d;
  logic signed [FTC_TRQ_W-1:0] tout_q;
  logic signed [FTC_TRQ_W-1:0] tout_d;
  logic signed [FTC_TRQ_W-1:0] fric_q;
  logic signed [FTC_TRQ_W-1:0] fric_d;
  logic tde_q;
  logic tde_d;
  logic [FTC_HGAIN_W-1:0] hg_q;
  logic [FTC_HGAIN_W-1:0] hg_d;
  logic [FTC_HFILT_W-1:0] hf_q;
  logic [FTC_HFILT_W-1:0] hf_d;
  logic pos_like;
  logic signed [ACC_W-1:0] pct_sum;
  logic signed [ACC_W-1:0] pct_trq;
  logic signed [ACC_W-1:0] visc;
  logic signed [ACC_W-1:0] total;

  function automatic logic signed [FTC_PCT_W-1:0] clip_pct(input logic signed [FTC_PCT_W-1:0] v);
    if (v > FTC_PCT_MAX) begin
      return FTC_PCT_MAX;
    end else if (v < FTC_PCT_MIN) begin
      return FTC_PCT_MIN;
    end
    return v;
  endfunction : clip_pct

  assign pos_like = (ctrl_mode == FTC_MODE_POS) || (ctrl_mode == FTC_MODE_FULL);

  always_comb begin
    dir_d = dir_q;
    seen_d = seen_q;
    off_d = off_q;
    dyn_d = dyn_q;
    if (!servo_on) begin
      dir_d = 2'h0;
      seen_d = 1'b0;
    end else if (pos_like && cmd.cmd_valid && cmd.cmd_delta != '0) begin
      seen_d = 1'b1;
      dir_d = (cmd.cmd_delta > 0) ? 2'h2 : 2'h1;
    end
    unique case (ctrl_mode)
      FTC_MODE_TRQ: begin
        off_d = '0;
        dyn_d = '0;
      end
      FTC_MODE_VEL: begin
        off_d = clip_pct(cfg.offset_load_torque_setting);
        dyn_d = '0;
      end
      FTC_MODE_POS, FTC_MODE_FULL: begin
        if (!servo_on) begin
          off_d = clip_pct(cfg.offset_load_torque_setting);
          dyn_d = '0;
        end else if (seen_d) begin
          off_d = clip_pct(cfg.offset_load_torque_setting);
          if (dir_d == 2'h2) begin
            dyn_d = clip_pct(cfg.forward_friction_torque_setting);
          end else if (dir_d == 2'h1) begin
            dyn_d = clip_pct(cfg.reverse_friction_torque_setting);
          end
        end
        // otherwise previous terms are held until the first command
      end
    endcase
  end

  // terms and direction form one group: the hold rule needs both together
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dir_q <= 2'h0;
      seen_q <= 1'b0;
      off_q <= '0;
      dyn_q <= '0;
    end else begin
      dir_q <= dir_d;
      seen_q <= seen_d;
      off_q <= off_d;
      dyn_q <= dyn_d;
    end
  end

  always_comb begin
    pct_sum = ACC_W'(off_d) + ACC_W'(dyn_d);
    pct_trq = (pct_sum * ACC_W'(RATED_TRQ)) / ACC_W'(100);
    visc = '0;
    if (two_dof_en && ctrl_mode != FTC_MODE_TRQ) begin
      // gain in 0.1 percent of rated per full-scale speed; gain widened as signed
      // so that a reverse speed gives a negative term, not a huge positive one
      visc = (ACC_W'(cmd.cmd_speed) * signed'(ACC_W'(cfg.viscous_friction_gain_setting))
             * ACC_W'(RATED_TRQ)) / (ACC_W'(FTC_VGAIN_UNIT) * ACC_W'(SPD_FULL));
    end
    total = ACC_W'(torque_in) + pct_trq + visc;
    if (total > TRQ_MAX) begin
      tout_d = FTC_TRQ_W'(TRQ_MAX);
    end else if (total < TRQ_MIN) begin
      tout_d = FTC_TRQ_W'(TRQ_MIN);
    end else begin
      tout_d = FTC_TRQ_W'(total);
    end
    if (pct_trq > TRQ_MAX) begin
      fric_d = FTC_TRQ_W'(TRQ_MAX);
    end else if (pct_trq < TRQ_MIN) begin
      fric_d = FTC_TRQ_W'(TRQ_MIN);
    end else begin
      fric_d = FTC_TRQ_W'(pct_trq);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tout_q <= '0;
      fric_q <= '0;
    end else begin
      tout_q <= tout_d;
      fric_q <= fric_d;
    end
  end

  // twist damping settings are only passed on, the loop itself lives elsewhere
  always_comb begin
    tde_d = (ctrl_mode == FTC_MODE_FULL) && servo_on;
    // out-of-range settings are clamped rather than refused
    hg_d = (cfg.twist_damping_gain_setting > FTC_HGAIN_MAX) ? FTC_HGAIN_MAX
           : cfg.twist_damping_gain_setting;
    hf_d = (cfg.twist_damping_filter_setting > FTC_HFILT_MAX) ? FTC_HFILT_MAX
           : cfg.twist_damping_filter_setting;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tde_q <= 1'b0;
      hg_q <= '0;
      hf_q <= '0;
    end else begin
      tde_q <= tde_d;
      hg_q <= hg_d;
      hf_q <= hf_d;
    end
  end

  assign torque_out = tout_q;
  assign friction_torque = fric_q;
  assign twist_damp_en = tde_q;
  assign twist_gain = hg_q;
  assign twist_filter = hf_q;
  assign cmd_dir = dir_q;

  a_trq_zero: assert property (@(posedge mclk) disable iff (reset)
    ctrl_mode == FTC_MODE_TRQ |=> friction_torque == 0)
    else $error("friction torque not zero in torque mode");
  a_damp_en: assert property (@(posedge mclk) disable iff (reset)
    twist_damp_en == $past(ctrl_mode == FTC_MODE_FULL && servo_on))
    else $error("twist damping enable wrong");
  a_dir_clear: assert property (@(posedge mclk) disable iff (reset)
    !servo_on |=> cmd_dir == 2'h0)
    else $error("direction not cleared at servo off");
  a_fwd_dir: assert property (@(posedge mclk) disable iff (reset)
    servo_on && pos_like && cmd.cmd_valid && cmd.cmd_delta > 0 |=> cmd_dir == 2'h2)
    else $error("forward direction not stored");
  a_rev_term: assert property (@(posedge mclk) disable iff (reset)
    servo_on && ctrl_mode == FTC_MODE_POS && cmd.cmd_valid && cmd.cmd_delta < 0
    |=> dyn_q == clip_pct($past(cfg.reverse_friction_torque_setting)))
    else $error("reverse friction term not applied");
  a_fwd_term: assert property (@(posedge mclk) disable iff (reset)
    servo_on && ctrl_mode == FTC_MODE_POS && cmd.cmd_valid && cmd.cmd_delta > 0
    |=> dyn_q == clip_pct($past(cfg.forward_friction_torque_setting)))
    else $error("forward friction term not applied");
  a_vel_off: assert property (@(posedge mclk) disable iff (reset)
    ctrl_mode == FTC_MODE_VEL |=> dyn_q == 0
    && off_q == clip_pct($past(cfg.offset_load_torque_setting)))
    else $error("velocity mode terms wrong");
  a_hold_terms: assert property (@(posedge mclk) disable iff (reset)
    servo_on && pos_like && !seen_q && !(cmd.cmd_valid && cmd.cmd_delta != 0)
    |=> off_q == $past(off_q) && dyn_q == $past(dyn_q))
    else $error("terms changed before first command");
  a_gain_lim: assert property (@(posedge mclk) disable iff (reset)
    twist_gain <= FTC_HGAIN_MAX && twist_filter <= FTC_HFILT_MAX)
    else $error("twist damping setting out of range");
  a_sum_pass: assert property (@(posedge mclk) disable iff (reset)
    ctrl_mode == FTC_MODE_TRQ && $past(ctrl_mode) == FTC_MODE_TRQ
    |=> torque_out == $past(torque_in))
    else $error("torque mode output altered");


  // direction and term bookkeeping
  a_rev_dir: assert property (@(posedge mclk) disable iff (reset)
    servo_on && pos_like && cmd.cmd_valid && cmd.cmd_delta < 0
    |=> cmd_dir == 2'h1)
    else $error("reverse direction not stored");
  a_dir_hold: assert property (@(posedge mclk) disable iff (reset)
    servo_on && !(pos_like && cmd.cmd_valid && cmd.cmd_delta != 0)
    |=> cmd_dir == $past(cmd_dir))
    else $error("direction changed without command");
  a_vel_dir: assert property (@(posedge mclk) disable iff (reset)
    servo_on && !pos_like
    |=> cmd_dir == $past(cmd_dir))
    else $error("direction changed outside position modes");
  a_seen_clear: assert property (@(posedge mclk) disable iff (reset)
    !servo_on
    |=> !seen_q)
    else $error("first command flag kept at servo off");
  a_off_load: assert property (@(posedge mclk) disable iff (reset)
    servo_on && pos_like && cmd.cmd_valid && cmd.cmd_delta != 0
    |=> off_q == clip_pct($past(cfg.offset_load_torque_setting)))
    else $error("offset term not loaded at first command");
  a_off_sv_off: assert property (@(posedge mclk) disable iff (reset)
    !servo_on && ctrl_mode != FTC_MODE_TRQ
    |=> off_q == clip_pct($past(cfg.offset_load_torque_setting)) && dyn_q == 0)
    else $error("servo off terms wrong");
  a_trq_terms: assert property (@(posedge mclk) disable iff (reset)
    ctrl_mode == FTC_MODE_TRQ
    |=> off_q == 0 && dyn_q == 0)
    else $error("torque mode terms not zero");
  a_fwd_hold: assert property (@(posedge mclk) disable iff (reset)
    servo_on && pos_like && seen_q && cmd_dir == 2'h2 && !cmd.cmd_valid
    |=> dyn_q == clip_pct($past(cfg.forward_friction_torque_setting)))
    else $error("forward term not kept between commands");
  a_rev_hold: assert property (@(posedge mclk) disable iff (reset)
    servo_on && pos_like && seen_q && cmd_dir == 2'h1 && !cmd.cmd_valid
    |=> dyn_q == clip_pct($past(cfg.reverse_friction_torque_setting)))
    else $error("reverse term not kept between commands");

  // output arithmetic and pass-through settings
  a_fric_sum: assert property (@(posedge mclk) disable iff (reset)
    ACC_W'(friction_torque)
    == ((ACC_W'(off_q) + ACC_W'(dyn_q)) * ACC_W'(RATED_TRQ)) / ACC_W'(100))
    else $error("friction torque not offset plus friction");
  a_no_visc: assert property (@(posedge mclk) disable iff (reset)
    !two_dof_en && ctrl_mode != FTC_MODE_TRQ |=> (ACC_W'($past(torque_in))
    + ACC_W'(friction_torque) > TRQ_MAX) || (ACC_W'($past(torque_in))
    + ACC_W'(friction_torque) < TRQ_MIN)
    || ACC_W'(torque_out) == ACC_W'($past(torque_in)) + ACC_W'(friction_torque))
    else $error("torque output not input plus compensation");
  a_damp_off: assert property (@(posedge mclk) disable iff (reset)
    !servo_on
    |=> !twist_damp_en)
    else $error("twist damping on with servo off");
  a_gain_pass: assert property (@(posedge mclk) disable iff (reset)
    cfg.twist_damping_gain_setting <= FTC_HGAIN_MAX
    |=> twist_gain == $past(cfg.twist_damping_gain_setting))
    else $error("twist gain not passed on");
  a_gain_clamp: assert property (@(posedge mclk) disable iff (reset)
    cfg.twist_damping_gain_setting > FTC_HGAIN_MAX
    |=> twist_gain == FTC_HGAIN_MAX)
    else $error("twist gain not clamped");
  a_filt_pass: assert property (@(posedge mclk) disable iff (reset)
    cfg.twist_damping_filter_setting <= FTC_HFILT_MAX
    |=> twist_filter == $past(cfg.twist_damping_filter_setting))
    else $error("twist filter not passed on");
  a_filt_clamp: assert property (@(posedge mclk) disable iff (reset)
    cfg.twist_damping_filter_setting > FTC_HFILT_MAX
    |=> twist_filter == FTC_HFILT_MAX)
    else $error("twist filter not clamped");

  c_fwd: cover property (@(posedge mclk) disable iff (reset) cmd_dir == 2'h2 ##1 cmd_dir == 2'h1);
  c_vel: cover property (@(posedge mclk) disable iff (reset) ctrl_mode == FTC_MODE_VEL && !servo_on);
  c_hold: cover property (@(posedge mclk) disable iff (reset) servo_on && pos_like && !seen_q);
  c_full: cover property (@(posedge mclk) disable iff (reset) twist_damp_en);
  c_sat: cover property (@(posedge mclk) disable iff (reset) torque_out == TRQ_MAX[FTC_TRQ_W-1:0]);
endmodule : ftc_core

// ===== tb/ftc_motion_ctrl.sv
// motion controller model issuing position steps and command speed
`timescale 1ns/1ps
module ftc_motion_ctrl
  import ftc_pkg::*;
(
  input wire logic mclk,
  input wire logic req_valid,
  input wire logic signed [FTC_SPD_W-1:0] req_delta,
  input wire logic signed [FTC_SPD_W-1:0] req_speed,
  output ftc_cmd_t cmd
);
  initial cmd = '0;
  // an idle step field toggles so a stale step never looks like a command
  always @(negedge mclk) begin
    cmd.cmd_valid <= req_valid;
    cmd.cmd_speed <= req_speed;
    cmd.cmd_delta <= req_valid ? req_delta : ~cmd.cmd_delta;
  end
endmodule : ftc_motion_ctrl

// ===== tb/friction_torque_compensation_bench.sv
// self-checking bench for the friction torque compensation block
`timescale 1ns/1ps
module friction_torque_compensation_bench;
  import ftc_pkg::*;
  localparam int RT = FTC_RATED_DEF;
  localparam int SF = FTC_SPD_FULL_DEF;
  typedef struct {
    logic signed [15:0] to, fr;
    logic en;
    logic [14:0] tg;
    logic [15:0] tf;
    logic [1:0] dr;
    logic dc;
  } ftc_exp_t;
  logic mclk = 1'b0, reset = 1'b1, servo_on = 1'b0, two_dof_en = 1'b0, twist_damp_en;
  ftc_mode_t ctrl_mode = FTC_MODE_TRQ, m;
  ftc_cfg_t cfg = '0, c;
  ftc_cmd_t cmd;
  logic signed [15:0] torque_in = '0, torque_out, friction_torque, ti, rs;
  logic [14:0] twist_gain;
  logic [15:0] twist_filter;
  logic [1:0] cmd_dir, dir_s = 2'h0;
  logic req_valid = 1'b0, so, td, rv, seen_s = 1'b0;
  logic signed [15:0] req_delta = '0, req_speed = '0;
  int rd, off_s = 0, dyn_s = 0, fail_count = 0, comparisons = 0;
  ftc_exp_t q[$], me;
  always #12.5 mclk = ~mclk;
  ftc_motion_ctrl u_ctrl (.mclk(mclk), .req_valid(req_valid), .req_delta(req_delta),
    .req_speed(req_speed), .cmd(cmd));
  ftc_core #(.RATED_TRQ(RT), .SPD_FULL(SF)) u_dut (.mclk(mclk), .reset(reset),
    .ctrl_mode(ctrl_mode), .servo_on(servo_on), .two_dof_en(two_dof_en), .cfg(cfg),
    .cmd(cmd), .torque_in(torque_in), .torque_out(torque_out),
    .friction_torque(friction_torque), .twist_damp_en(twist_damp_en),
    .twist_gain(twist_gain), .twist_filter(twist_filter), .cmd_dir(cmd_dir));
  function automatic int clp(int x);
    return x > 100 ? 100 : (x < -100 ? -100 : x);
  endfunction : clp
  function automatic logic signed [15:0] sat(longint x);
    return x > 32767 ? 16'sh7fff : (x < -32768 ? 16'sh8000 : 16'(x));
  endfunction : sat
  function automatic logic signed [7:0] pc();
    return 8'(25 * int'($urandom % 11) - 125);
  endfunction : pc
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic step();
    int f;
    longint v;
    @(posedge mclk);
    #2;
    req_valid = rv;
    req_delta = 16'(rd);
    req_speed = rs;
    @(negedge mclk);
    ctrl_mode <= m;
    servo_on <= so;
    two_dof_en <= td;
    cfg <= c;
    torque_in <= ti;
    if (!so) begin
      dir_s = 2'h0;
      seen_s = 1'b0;
    end else if ((m == FTC_MODE_POS || m == FTC_MODE_FULL) && rv && rd != 0) begin
      seen_s = 1'b1;
      dir_s = rd > 0 ? 2'h2 : 2'h1;
    end
    if (m == FTC_MODE_TRQ) begin
      off_s = 0;
      dyn_s = 0;
    end else if (m == FTC_MODE_VEL || !so) begin
      off_s = clp(c.offset_load_torque_setting);
      dyn_s = 0;
    end else if (seen_s) begin
      off_s = clp(c.offset_load_torque_setting);
      dyn_s = clp(dir_s == 2'h2 ? c.forward_friction_torque_setting
                                : c.reverse_friction_torque_setting);
    end
    f = (off_s + dyn_s) * RT / 100;
    v = (td && m != FTC_MODE_TRQ) ?
        longint'(rs) * longint'(c.viscous_friction_gain_setting) * RT / (1000 * SF) : 0;
    q.push_back('{sat(v + ti + f), sat(f), m == FTC_MODE_FULL && so,
      c.twist_damping_gain_setting > FTC_HGAIN_MAX ? FTC_HGAIN_MAX : c.twist_damping_gain_setting,
      c.twist_damping_filter_setting > FTC_HFILT_MAX ? FTC_HFILT_MAX : c.twist_damping_filter_setting,
      dir_s, m == FTC_MODE_POS || m == FTC_MODE_FULL || !so});
  endtask : step
  task automatic go(ftc_mode_t mm, logic s, logic t, logic v, int d, int n);
    m = mm;
    so = s;
    td = t;
    rv = v;
    rd = d;
    repeat (n) step();
  endtask : go
  always @(posedge mclk) begin
    if (q.size() > 0) begin
      me = q.pop_front();
      #1;
      check("torque_out", torque_out, me.to);
      check("friction_torque", friction_torque, me.fr);
      check("twist_damp_en", twist_damp_en, me.en);
      check("twist_gain", twist_gain, me.tg);
      check("twist_filter", twist_filter, me.tf);
      if (me.dc) check("cmd_dir", cmd_dir, me.dr);
    end
  end
  initial begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    end_sim();
  end
  initial begin
    int k;
    void'($urandom(71));
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    c = '{8'sd100, 8'sd50, -8'sd25, 14'h3e8, 15'h7531, 16'h9089};
    ti = 16'sh0100;
    rs = 16'sd10000;
    go(FTC_MODE_TRQ, 1, 1, 1, 5, 3);
    c.offset_load_torque_setting = -8'sd25;
    go(FTC_MODE_VEL, 0, 1, 1, 5, 3);
    go(FTC_MODE_POS, 0, 0, 0, 0, 2);
    c.offset_load_torque_setting = 8'sd75;
    go(FTC_MODE_POS, 1, 0, 0, 0, 3);
    go(FTC_MODE_POS, 1, 0, 1, 5, 1);
    go(FTC_MODE_POS, 1, 0, 0, 0, 4);
    go(FTC_MODE_FULL, 1, 1, 1, -5, 2);
    c.twist_damping_gain_setting = 15'h0190;
    for (int j = 0; j < 4; j++) begin
      c.twist_damping_filter_setting = 16'(j * 500);
      go(FTC_MODE_FULL, 1, 0, 0, 0, 1);
    end
    go(FTC_MODE_FULL, 0, 0, 0, 0, 2);
    c.offset_load_torque_setting = 8'sd120;
    ti = 16'sh7d00;
    go(FTC_MODE_POS, 1, 0, 1, 5, 2);
    $display("test directed done");
    for (int i = 0; i < 60; i++) begin
      k = $urandom % 3;
      m = ftc_mode_t'($urandom % 4);
      so = 1'($urandom % 2);
      td = 1'($urandom % 2);
      rv = 1'($urandom % 2);
      rd = 5 * (int'($urandom % 3) - 1);
      rs = k == 0 ? 16'sd10000 : (k == 1 ? -16'sd5000 : 16'sd3);
      c = '{pc(), pc(), pc(), k == 0 ? 14'h3e8 : (k == 1 ? 14'h7d0 : 14'h0),
        15'($urandom), 16'($urandom)};
      ti = 16'($urandom);
      step();
    end
    $display("test random done");
    repeat (3) @(posedge mclk);
    end_sim();
  end
endmodule : friction_torque_compensation_bench
